// file: logic/ram_pkg.sv
// Shared constants and types for the parameterised RAM and its user end.
// Assumes one system clock, clk_sys, for both ends of the link.
package ram_pkg;

    // ========================================================================
    // Register selects and variants
    // ========================================================================
    // Register select choices for the data, address and output paths.
    typedef enum logic [1:0]
    {
        REGISTERED   = 2'b00,
        UNREGISTERED = 2'b01,
        UNUSED       = 2'b10
    } reg_sel_t;

    // The two RAM variants.
    typedef enum logic
    {
        VAR_DUAL   = 1'b0,
        VAR_SINGLE = 1'b1
    } variant_t;

    // ========================================================================
    // Default sizes and timing counts
    // ========================================================================
    localparam int DEF_WIDTH      = 8;
    localparam int DEF_ADDR_WIDTH = 8;
    localparam int MAX_ADDR_WIDTH = 30;
    // Cycles from the address on the link to valid read data, default setup.
    localparam int DEF_RD_LAT     = 2;
    localparam int MAX_RD_LAT     = 7;
    localparam int CNT_WIDTH      = 3;

endpackage : ram_pkg

// file: logic/ram_if.sv
// Link between the RAM and the user logic that drives it.
// Assumes both ends run on the same clk_sys; no clocking block is used.
interface ram_if #(
    parameter int WIDTH      = ram_pkg::DEF_WIDTH,
    parameter int ADDR_WIDTH = ram_pkg::DEF_ADDR_WIDTH
);
    // Write side; in the single-port variant wr_addr is the only address.
    logic [ADDR_WIDTH-1:0] wr_addr;
    logic [WIDTH-1:0]      wr_data;
    logic                  wr_en;
    logic                  wr_clken;
    // Read side; rd_addr and rd_en are ignored by the single-port variant.
    logic [ADDR_WIDTH-1:0] rd_addr;
    logic                  rd_en;
    logic                  rd_clken;
    logic [WIDTH-1:0]      rd_data;

    // The RAM end.
    modport ram_end
    (
        input  wr_addr,
        input  wr_data,
        input  wr_en,
        input  wr_clken,
        input  rd_addr,
        input  rd_en,
        input  rd_clken,
        output rd_data
    );

    // The user logic end.
    modport user_end
    (
        output wr_addr,
        output wr_data,
        output wr_en,
        output wr_clken,
        output rd_addr,
        output rd_en,
        output rd_clken,
        input  rd_data
    );

endinterface : ram_if

// file: logic/ram_core.sv
// Parameterised RAM: simple dual-port or single-port variant.
// Assumes the user end drives every link input; all logic on clk_sys.
module ram_core #(
    parameter int                WIDTH       = ram_pkg::DEF_WIDTH,
    parameter int                ADDR_WIDTH  = ram_pkg::DEF_ADDR_WIDTH,
    parameter int                DEPTH       = 2 ** ADDR_WIDTH,
    parameter ram_pkg::variant_t VARIANT     = ram_pkg::VAR_DUAL,
    parameter bit                WR_CLK_USED = 1'b1,
    parameter bit                RD_CLK_USED = 1'b1,
    parameter bit                RD_EN_USED  = 1'b1,
    parameter ram_pkg::reg_sel_t IN_SEL      = ram_pkg::REGISTERED,
    parameter ram_pkg::reg_sel_t OUT_SEL     = ram_pkg::REGISTERED,
    parameter ram_pkg::reg_sel_t ADDR_SEL    = ram_pkg::REGISTERED,
    parameter bit                INIT_USED   = 1'b0,
    parameter logic [DEPTH*WIDTH-1:0] INIT_IMAGE = '0
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    ram_if.ram_end   bus
);
    import ram_pkg::*;

    // ========================================================================
    // Configuration
    // ========================================================================
    localparam bit IS_DUAL = (VARIANT == VAR_DUAL);
    // Write address and strobe captured on the write clock.
    localparam bit WR_CTL_REG = WR_CLK_USED && (IS_DUAL || ADDR_SEL == REGISTERED);
    localparam bit WR_DAT_REG = WR_CLK_USED && (IN_SEL == REGISTERED);
    // The single-port read address is the shared address register.
    localparam bit RD_ADR_REG = IS_DUAL ? (RD_CLK_USED && ADDR_SEL == REGISTERED)
                                        : WR_CTL_REG;
    localparam bit OUT_REG    = RD_CLK_USED && (OUT_SEL == REGISTERED);

    // Refuse settings that the logic cannot serve.
    if (ADDR_WIDTH < 1 || ADDR_WIDTH > MAX_ADDR_WIDTH || WIDTH < 1 || DEPTH < 1)
    begin : g_bad_size
        $error("ram_core: width, address width or depth out of range.");
    end
    if (IS_DUAL && !(DEPTH > 2 ** (ADDR_WIDTH - 1) && DEPTH <= 2 ** ADDR_WIDTH))
    begin : g_bad_depth
        $error("ram_core: dual-port depth outside its allowed range.");
    end
    if ($bits(bus.wr_data) != WIDTH || $bits(bus.wr_addr) != ADDR_WIDTH)
    begin : g_bad_link
        $error("ram_core: link widths differ from the RAM widths.");
    end
    if (!WR_CLK_USED && (IN_SEL == REGISTERED || (!IS_DUAL && ADDR_SEL == REGISTERED)))
    begin : g_bad_wr
        $error("ram_core: without an input clock inputs must be unregistered.");
    end
    if (!RD_CLK_USED && (OUT_SEL == REGISTERED || (IS_DUAL && ADDR_SEL == REGISTERED)))
    begin : g_bad_rd
        $error("ram_core: without an output clock outputs must be unregistered.");
    end
    if (IS_DUAL && (IN_SEL == UNUSED || OUT_SEL == UNUSED || ADDR_SEL == UNUSED))
    begin : g_bad_sel
        $error("ram_core: the dual-port variant takes only two select values.");
    end
    if (INIT_USED && !WR_CTL_REG)
    begin : g_bad_init
        $error("ram_core: an initial image needs a registered write strobe.");
    end

    // ========================================================================
    // Types, storage and helpers
    // ========================================================================
    typedef logic [WIDTH-1:0] word_t;
    typedef word_t            mem_t [DEPTH];

    // All flip-flop state of the RAM.
    typedef struct packed
    {
        logic [ADDR_WIDTH-1:0] wa;
        word_t                 wd;
        logic                  we;
        logic                  wce;
        logic [ADDR_WIDTH-1:0] ra;
        logic                  re;
        word_t                 q;
        word_t                 old;
    } state_t;

    // Builds the start-up contents from the image, or zeros.
    function automatic mem_t init_mem();
        mem_t m;
        for (int i = 0; i < DEPTH; i++)
        begin
            m[i] = INIT_USED ? INIT_IMAGE[i*WIDTH +: WIDTH] : '0;
        end
        return m;
    endfunction : init_mem

    // Tells whether an address falls inside the storage.
    function automatic logic in_depth(logic [ADDR_WIDTH-1:0] a);
        return int'(a) < DEPTH;
    endfunction : in_depth

    mem_t                  mem = init_mem();
    state_t                s_q;
    state_t                s_d;
    logic [ADDR_WIDTH-1:0] wr_addr_eff;
    logic                  wr_en_eff;
    word_t                 wr_data_eff;
    logic [ADDR_WIDTH-1:0] rd_addr_eff;
    logic                  rd_en_eff;
    word_t                 rd_word;
    word_t                 rd_hold;

    // ========================================================================
    // Registers
    // ========================================================================
    // Next state: each side's registers load only while its enable is high, except wce, which copies wr_clken every cycle.
    always_comb
    begin
        s_d     = s_q;
        s_d.wce = bus.wr_clken;
        if (bus.wr_clken)
        begin
            s_d.wa = bus.wr_addr;
            s_d.we = bus.wr_en;
            s_d.wd = bus.wr_data;
            // Keeps the word that the captured write is about to replace.
            s_d.old = mem[bus.wr_addr];
        end
        if (bus.rd_clken)
        begin
            s_d.ra = bus.rd_addr;
            s_d.re = RD_EN_USED ? bus.rd_en : 1'b1;
            s_d.q  = rd_hold;
        end
        if (!nrst)
        begin
            s_d = '0;
        end
    end

    // Registers every field of the state on the rising edge.
    always_ff @(posedge clk_sys)
    begin
        s_q <= s_d;
    end

    // ========================================================================
    // Write path
    // ========================================================================
    // Selects captured or direct write address, strobe and data.
    assign wr_addr_eff = WR_CTL_REG ? s_q.wa : bus.wr_addr;
    assign wr_en_eff   = WR_CTL_REG ? (s_q.we && s_q.wce) : bus.wr_en;
    assign wr_data_eff = WR_DAT_REG ? s_q.wd : bus.wr_data;

    if (WR_CTL_REG)
    begin : g_wr_sync
        // Writes in the low phase after the capturing edge, so a read
        // taken at that same rising edge still sees the old word.
        always_ff @(negedge clk_sys)
        begin
            if (wr_en_eff && in_depth(wr_addr_eff))
            begin
                mem[wr_addr_eff] <= wr_data_eff;
            end
        end
    end
    else
    begin : g_wr_level
        // Level write: every address presented while the strobe is high
        // takes the data, so the user must hold the address steady.
        always_latch
        begin
            if (wr_en_eff && in_depth(wr_addr_eff))
            begin
                mem[wr_addr_eff] = wr_data_eff;
            end
        end
    end

    // ========================================================================
    // Read path
    // ========================================================================
    // Picks the read address and strobe; the single-port variant reads
    // at its one address and always reads.
    always_comb
    begin
        if (IS_DUAL)
        begin
            rd_addr_eff = RD_ADR_REG ? s_q.ra : bus.rd_addr;
            rd_en_eff   = RD_ADR_REG ? s_q.re : (RD_EN_USED ? bus.rd_en : 1'b1);
        end
        else
        begin
            rd_addr_eff = wr_addr_eff;
            rd_en_eff   = 1'b1;
        end
        rd_word = in_depth(rd_addr_eff) ? mem[rd_addr_eff] : 'x;
        // A read captured at the same edge as a write to its address would
        // otherwise see the new word once the write lands in the low phase.
        if (WR_CTL_REG && RD_ADR_REG && wr_en_eff && rd_addr_eff == wr_addr_eff)
        begin
            rd_word = s_q.old;
        end
    end

    // Holds the last word read while the read strobe is low.
    always_latch
    begin
        if (rd_en_eff)
        begin
            rd_hold = rd_word;
        end
    end

    // Output from the read-clocked register or straight from the latch.
    assign bus.rd_data = OUT_REG ? s_q.q : rd_hold;

endmodule : ram_core

// file: logic/ram_user.sv
// User logic end: turns single read and write commands into RAM link cycles.
// Assumes the RAM end shares clk_sys and its settings match ASYNC_WR, RD_LAT.
module ram_user #(
    parameter int WIDTH      = ram_pkg::DEF_WIDTH,
    parameter int ADDR_WIDTH = ram_pkg::DEF_ADDR_WIDTH,
    parameter bit ASYNC_WR   = 1'b0,
    parameter int RD_LAT     = ram_pkg::DEF_RD_LAT
)
(
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire logic                  cmd_valid,
    input  wire logic                  cmd_write,
    input  wire logic [ADDR_WIDTH-1:0] cmd_addr,
    input  wire logic [WIDTH-1:0]      cmd_data,
    output logic                       cmd_ready,
    output logic                       rsp_valid,
    output logic [WIDTH-1:0]           rsp_data,
    ram_if.user_end                    bus
);
    import ram_pkg::*;

    if (RD_LAT < 0 || RD_LAT > MAX_RD_LAT)
    begin : g_bad_lat
        $error("ram_user: read latency out of range.");
    end

    // ========================================================================
    // State
    // ========================================================================
    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_STROBE = 3'b010,
        ST_HOLD   = 3'b011,
        ST_READ   = 3'b100
    } phase_t;

    typedef struct packed
    {
        phase_t                ph;
        logic [ADDR_WIDTH-1:0] addr;
        logic [WIDTH-1:0]      data;
        logic                  we;
        logic                  re;
        logic [CNT_WIDTH-1:0]  cnt;
        logic                  ready;
        logic                  rvalid;
        logic [WIDTH-1:0]      rdata;
    } ustate_t;

    ustate_t s_q;
    ustate_t s_d;

    // Sequencer: level writes get setup, strobe and hold cycles with the
    // address held steady throughout.
    always_comb
    begin
        s_d        = s_q;
        s_d.rvalid = 1'b0;
        case (s_q.ph)
            ST_IDLE:
            begin
                if (cmd_valid && s_q.ready)
                begin
                    s_d.addr  = cmd_addr;
                    s_d.data  = cmd_data;
                    s_d.ready = 1'b0;
                    if (cmd_write)
                    begin
                        s_d.ph = ASYNC_WR ? ST_SETUP : ST_STROBE;
                        s_d.we = !ASYNC_WR;
                    end
                    else
                    begin
                        s_d.ph  = ST_READ;
                        s_d.re  = 1'b1;
                        s_d.cnt = CNT_WIDTH'(RD_LAT);
                    end
                end
            end
            ST_SETUP:
            begin
                s_d.ph = ST_STROBE;
                s_d.we = 1'b1;
            end
            ST_STROBE:
            begin
                s_d.we    = 1'b0;
                s_d.ph    = ASYNC_WR ? ST_HOLD : ST_IDLE;
                s_d.ready = !ASYNC_WR;
            end
            ST_HOLD:
            begin
                s_d.ph    = ST_IDLE;
                s_d.ready = 1'b1;
            end
            ST_READ:
            begin
                if (s_q.cnt == '0)
                begin
                    s_d.rvalid = 1'b1;
                    s_d.rdata  = bus.rd_data;
                    s_d.re     = 1'b0;
                    s_d.ph     = ST_IDLE;
                    s_d.ready  = 1'b1;
                end
                else
                begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end
            default:
            begin
                s_d.ph = ST_IDLE;
            end
        endcase
        if (!nrst)
        begin
            s_d       = '0;
            s_d.ready = 1'b1;
        end
    end

    // Registers the whole state on the shared clock.
    always_ff @(posedge clk_sys)
    begin
        s_q <= s_d;
    end

    // ========================================================================
    // Link and user outputs
    // ========================================================================
    // One address serves both sides; both clock enables stay high.
    assign bus.wr_addr  = s_q.addr;
    assign bus.rd_addr  = s_q.addr;
    assign bus.wr_data  = s_q.data;
    assign bus.wr_en    = s_q.we;
    assign bus.rd_en    = s_q.re;
    assign bus.wr_clken = 1'b1;
    assign bus.rd_clken = 1'b1;
    assign cmd_ready    = s_q.ready;
    assign rsp_valid    = s_q.rvalid;
    assign rsp_data     = s_q.rdata;

endmodule : ram_user

// file: bench/ram_link_sva.sv
// Assertions on the link between the user end and the RAM core.
// Assumes the default setup: dual port, every stage registered, RD_LAT of 2.
module ram_link_sva #(
    parameter int WIDTH      = ram_pkg::DEF_WIDTH,
    parameter int ADDR_WIDTH = ram_pkg::DEF_ADDR_WIDTH
)
(
    input wire logic                  clk_sys,
    input wire logic                  nrst,
    input wire logic [ADDR_WIDTH-1:0] wr_addr,
    input wire logic [WIDTH-1:0]      wr_data,
    input wire logic                  wr_en,
    input wire logic                  wr_clken,
    input wire logic [ADDR_WIDTH-1:0] rd_addr,
    input wire logic                  rd_en,
    input wire logic                  rd_clken,
    input wire logic [WIDTH-1:0]      rd_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // ========================================================================
    // Sequences
    // ========================================================================
    // One default clock and reset serve every property below.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // A read holds its strobe for the address stage and two more cycles.
    sequence s_rd_window;
        rd_en [*3] ##1 !rd_en;
    endsequence

    // The strobe has been low for two cycles after a read ended.
    sequence s_rd_idle;
        $fell(rd_en) ##1 !rd_en ##1 !rd_en;
    endsequence

    // Remembers the last word written on the link, so a later read of that
    // address can be held against it without a long repetition.
    logic                  lw_valid = 1'b0;
    logic [ADDR_WIDTH-1:0] lw_addr;
    logic [WIDTH-1:0]      lw_data;
    always_ff @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            lw_valid <= 1'b1;
            lw_addr  <= wr_addr;
            lw_data  <= wr_data;
        end
    end

    // A read of the last written address, with no write beside or after it.
    sequence s_rd_last_wr;
        (rd_en && !wr_en && lw_valid && rd_addr == lw_addr) ##1 (!wr_en);
    endsequence

    // Two edges after the read strobe, the output shows the written word.
    property p_wr_then_rd;
        s_rd_last_wr |-> ##1 (rd_data == lw_data);
    endproperty

    // ========================================================================
    // Assertions
    // ========================================================================
    a_wr_then_rd: assert property (p_wr_then_rd)
        else $error("read after write returned other data");
    a_rd_strobe_len: assert property ($rose(rd_en) |-> s_rd_window)
        else $error("read strobe length wrong");
    a_rd_hold_latch: assert property (s_rd_idle |-> $stable(rd_data))
        else $error("read data moved while strobe low");
    a_wr_pulse_once: assert property ($rose(wr_en) |=> !wr_en)
        else $error("write strobe longer than one cycle");
    a_clken_high: assert property (wr_clken && rd_clken)
        else $error("clock enable low");
    a_port_excl: assert property (!(wr_en && rd_en))
        else $error("read and write strobes together");
    a_addr_shared: assert property (rd_addr == wr_addr)
        else $error("read and write addresses differ");
    a_reset_clear: assert property ($rose(nrst) |-> rd_data == '0)
        else $error("read data not cleared by reset");

endmodule : ram_link_sva

// file: bench/tb_top.sv
// Testbench joining the user end and the RAM core through the link.
// Assumes default parameters on both ends and a 100 MHz clk_sys.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int W  = ram_pkg::DEF_WIDTH;
    localparam int AW = ram_pkg::DEF_ADDR_WIDTH;

    logic          clk_sys   = 1'b0;
    logic          nrst      = 1'b0;
    logic          cmd_valid = 1'b0;
    logic          cmd_write = 1'b0;
    logic [AW-1:0] cmd_addr  = '0;
    logic [W-1:0]  cmd_data  = '0;
    logic          cmd_ready;
    logic          rsp_valid;
    logic [W-1:0]  rsp_data;
    int            fail_count  = 0;
    int            checks_done = 0;
    logic [AW-1:0] tbl_a [4] = '{8'h00, 8'hff, 8'h55, 8'haa};
    logic [W-1:0]  tbl_d [4] = '{8'ha5, 8'h5a, 8'hff, 8'h01};

    // ========================================================================
    // Clock, design and checker
    // ========================================================================
    // The clock toggles every half period of 5 ns.
    always #5 clk_sys = ~clk_sys;

    ram_if #(.WIDTH(W), .ADDR_WIDTH(AW)) bus ();

    ram_core #(.WIDTH(W), .ADDR_WIDTH(AW)) ram_core_inst (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .bus     (bus)
    );

    ram_user #(.WIDTH(W), .ADDR_WIDTH(AW)) ram_user_inst (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .cmd_valid (cmd_valid),
        .cmd_write (cmd_write),
        .cmd_addr  (cmd_addr),
        .cmd_data  (cmd_data),
        .cmd_ready (cmd_ready),
        .rsp_valid (rsp_valid),
        .rsp_data  (rsp_data),
        .bus       (bus)
    );

    ram_link_sva #(.WIDTH(W), .ADDR_WIDTH(AW)) link_chk (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .wr_addr  (bus.wr_addr),
        .wr_data  (bus.wr_data),
        .wr_en    (bus.wr_en),
        .wr_clken (bus.wr_clken),
        .rd_addr  (bus.rd_addr),
        .rd_en    (bus.rd_en),
        .rd_clken (bus.rd_clken),
        .rd_data  (bus.rd_data)
    );

    // ========================================================================
    // Tasks
    // ========================================================================
    // Compares one value and counts the result.
    task automatic chk(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Presents one command and returns at the edge that takes it.
    task automatic send(input logic w, input logic [AW-1:0] a, input logic [W-1:0] d);
        int n;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr  <= a;
        cmd_data  <= d;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (cmd_ready !== 1'b1 && n < 20);
        cmd_valid <= 1'b0;
        // A command that is never taken counts as a mismatch.
        if (cmd_ready !== 1'b1)
        begin
            fail_count++;
            $display("MISMATCH cmd_ready expected 1 seen %b", cmd_ready);
        end
    endtask : send

    // Writes one word and checks the strobe cycle on the link.
    task automatic do_write(input logic [AW-1:0] a, input logic [W-1:0] d);
        send(1'b1, a, d);
        @(posedge clk_sys);
        chk("wr_en", W'(1), W'(bus.wr_en));
        chk("wr_addr", a, bus.wr_addr);
        chk("wr_data", d, bus.wr_data);
    endtask : do_write

    // Reads one word, checking its latency and its value.
    task automatic do_read(input logic [AW-1:0] a, input logic [W-1:0] exp);
        int n;
        send(1'b0, a, '0);
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (rsp_valid !== 1'b1 && n < 20);
        chk("latency", W'(ram_pkg::DEF_RD_LAT + 2), W'(n));
        chk("rsp_data", exp, rsp_data);
    endtask : do_read

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    // ========================================================================
    // Tests
    // ========================================================================
    // Main sequence of tests.
    initial
    begin
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        chk("rd_data", '0, bus.rd_data);
        do_read(8'h05, 8'h00);
        $display("test reset and start-up contents done");
        foreach (tbl_a[i]) do_write(tbl_a[i], tbl_d[i]);
        foreach (tbl_a[i]) do_read(tbl_a[i], tbl_d[i]);
        $display("test write and read boundaries done");
        do_write(8'h55, 8'h3c);
        do_write(8'h55, 8'hc3);
        do_read(8'h55, 8'hc3);
        $display("test overwrite done");
        do_read(8'haa, 8'h01);
        do_write(8'haa, 8'h7e);
        repeat (4) @(posedge clk_sys);
        chk("held", 8'h01, bus.rd_data);
        do_read(8'haa, 8'h7e);
        $display("test read latch hold done");
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        chk("rd_data", '0, bus.rd_data);
        do_read(8'h00, 8'ha5);
        do_read(8'hff, 8'h5a);
        $display("test reset keeps contents done");
        conclude();
    end

    // Cuts a hang short well beyond the expected run length.
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        fail_count++;
        conclude();
    end

endmodule : tb_top
